// File: hw/sso_pkg.sv
// Purpose: Constants for the servo status and enable block
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes:   Offsets, reset values and field positions live here
package sso_pkg;
	localparam int DW = 32;
	localparam int AW = 8;
	localparam int VW = 16;

	localparam logic [AW-1:0] OFS_CTRL    = 8'h00;
	localparam logic [AW-1:0] OFS_DONE_W  = 8'h04;
	localparam logic [AW-1:0] OFS_MATCH   = 8'h08;
	localparam logic [AW-1:0] OFS_RUN_LVL = 8'h0C;
	localparam logic [AW-1:0] OFS_OSEL1   = 8'h10;
	localparam logic [AW-1:0] OFS_STATUS  = 8'h14;
	localparam logic [AW-1:0] OFS_RUN_MON = 8'h18;

	localparam int CTRL_MAP_LSB  = 0;
	localparam int CTRL_MODE_LSB = 4;
	localparam int CTRL_SERIAL   = 6;

	localparam logic [3:0]  EN_MAP_HONOUR = 4'h0;
	localparam logic [3:0]  EN_MAP_FORCED = 4'h7;
	localparam logic [3:0]  RST_EN_MAP    = 4'h8;
	localparam logic [7:0]  DONE_W_MAX    = 8'hFA;
	localparam logic [7:0]  RST_DONE_W    = 8'h07;
	localparam logic [15:0] RST_MATCH     = 16'h000A;
	localparam logic [15:0] RST_RUN_LVL   = 16'h0014;
	localparam logic [15:0] RST_OSEL1     = 16'h0000;

	typedef enum logic [1:0] {
		SSO_MODE_POS,
		SSO_MODE_SPEED,
		SSO_MODE_TORQUE,
		SSO_MODE_RSVD
	} sso_mode_t;
	localparam sso_mode_t RST_MODE = SSO_MODE_POS;
endpackage

// File: hw/sso_cmp_if.sv
// Purpose: Carries one threshold comparison between modules
// Assumes: Values are signed two's complement
// Notes:   above selects greater-than, otherwise at-or-below
`timescale 1ns/1ns
interface sso_cmp_if;
	logic signed [15:0] a;
	logic signed [15:0] b;
	logic        [15:0] limit;
	logic               above;
	logic               hit;
	modport user (output a, output b, output limit, output above,
		input hit);
	modport cmp (input a, input b, input limit, input above,
		output hit);
endinterface

// File: hw/sso_cmp.sv
// Purpose: Magnitude of a difference compared against a limit
// Assumes: Combinational; the caller registers the result
// Notes:   No hysteresis
`timescale 1ns/1ns
module sso_cmp (
	sso_cmp_if.cmp c
);
	logic signed [16:0] diff;
	logic        [16:0] mag;

	always_comb begin
		diff = 17'(c.a) - 17'(c.b);
		mag  = diff[16] ? 17'(-diff) : 17'(diff);
		c.hit = c.above ? (mag > {1'b0, c.limit})
			: (mag <= {1'b0, c.limit});
	end
endmodule // sso_cmp

// File: hw/sso_map.sv
// Purpose: Allocates status flags onto the three output pairs
// Assumes: Flags active high; select nibble 0 means default pair
// Notes:   Several flags on one pair are ORed
`timescale 1ns/1ns
module sso_map (
	input  wire logic        slot_flag,
	input  wire logic        run_flag,
	input  wire logic [3:0]  slot_sel,
	input  wire logic [3:0]  run_sel,
	output      logic [2:0]  pair
);
	logic [2:0] slot_hot;
	logic [2:0] run_hot;

	always_comb begin
		slot_hot = 3'h0;
		run_hot  = 3'h0;
		unique case (slot_sel)
			4'h0, 4'h1: slot_hot = 3'h1;
			4'h2:       slot_hot = 3'h2;
			4'h3:       slot_hot = 3'h4;
			default:    slot_hot = 3'h0;
		endcase
		unique case (run_sel)
			4'h1:       run_hot = 3'h1;
			4'h0, 4'h2: run_hot = 3'h2;
			4'h3:       run_hot = 3'h4;
			default:    run_hot = 3'h0;
		endcase
		pair = ({3{slot_flag}} & slot_hot) | ({3{run_flag}} & run_hot);
	end
endmodule // sso_map

// File: hw/sso_top.sv
// Purpose: Servo enable and status outputs with Wishbone registers
// Assumes: Error and speed inputs come from logic on CLK_SYS
// Notes:   Status outputs are active low and follow inputs by one clock
//
// Contract
// R1 - Enable pin is active low: low enables the motor, high disables it.
// R2 - Map 0 honours the enable pin; map 7 forces the servo enabled.
// R3 - Done output low while position error within width, high otherwise.
// R4 - Done width ranges 0 to 250 and resets to 7.
// R5 - Width counts gear pulses, or position units under serial commands.
// R6 - Shared slot: done in position, match in speed, asserted in torque.
// R7 - Match output low while speed error within setting, high otherwise.
// R8 - Running output low while motor speed above level, else high.
// R9 - Running is shown on output, in status and in the monitor view.
// R10 - First output select resets to zero: slot on pair 1, running pair 2.
// R11 - Host starts and stops motion by references, not by enable.
// R12 - Signals sharing one output pair are ORed.
// R13 - Comparisons are re-evaluated every clock, without hysteresis.
`timescale 1ns/1ns
module sso_top (
	input  wire logic        CLK_SYS,
	input  wire logic        RST_B,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output      logic [31:0] WB_DAT_O,
	output      logic        WB_ACK_O,
	input  wire logic        SERVO_ON_N,
	input  wire logic [15:0] POS_ERR_PULSE,
	input  wire logic [15:0] POS_ERR_UNIT,
	input  wire logic [15:0] SPEED_REF,
	input  wire logic [15:0] MOTOR_SPEED,
	output      logic        SERVO_ENABLE,
	output      logic        POS_DONE_N,
	output      logic        SPEED_MATCH_N,
	output      logic        RUNNING_N,
	output      logic [2:0]  OUT_PAIR_N
);
	// Configuration registers
	logic [3:0]         enable_input_map;
	sso_pkg::sso_mode_t ctrl_mode;
	logic               serial_cmd;
	logic [7:0]         position_done_width;
	logic [15:0]        match_level;
	logic [15:0]        run_level;
	logic [15:0]        output_select_first;

	// Bus decode
	logic               bus_req;
	logic               wr_now;
	logic [31:0]        cur_word;
	logic [31:0]        wr_word;
	logic [31:0]        next_rdata;

	// Enable input synchroniser
	logic               son_meta;
	logic               son_sync;
	logic               next_enable;

	// Comparison results and slot selection
	sso_cmp_if          done_c ();
	sso_cmp_if          match_c ();
	sso_cmp_if          run_c ();
	logic               slot_flag;
	logic [2:0]         pair_act;
	logic [15:0]        speed_mag;
	logic [15:0]        running_monitor_view;
	logic               pos_done;
	logic               speed_match;
	logic               running;

	// Wishbone classic slave
	assign bus_req = WB_CYC_I & WB_STB_I;
	assign wr_now  = bus_req & WB_WE_I & WB_ACK_O;

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			WB_ACK_O <= 1'b0;
		end else begin
			WB_ACK_O <= bus_req & ~WB_ACK_O;
		end
	end

	always_comb begin
		cur_word = 32'h0000_0000;
		unique case (WB_ADR_I)
			sso_pkg::OFS_CTRL: begin
				cur_word[sso_pkg::CTRL_MAP_LSB +: 4] = enable_input_map;
				cur_word[sso_pkg::CTRL_MODE_LSB +: 2] = ctrl_mode;
				cur_word[sso_pkg::CTRL_SERIAL] = serial_cmd;
			end
			sso_pkg::OFS_DONE_W:  cur_word[7:0]  = position_done_width;
			sso_pkg::OFS_MATCH:   cur_word[15:0] = match_level;
			sso_pkg::OFS_RUN_LVL: cur_word[15:0] = run_level;
			sso_pkg::OFS_OSEL1:   cur_word[15:0] = output_select_first;
			sso_pkg::OFS_STATUS: begin
				cur_word[0] = pos_done;
				cur_word[1] = speed_match;
				cur_word[2] = running; // R9
				cur_word[3] = SERVO_ENABLE;
				cur_word[6:4] = pair_act;
			end
			sso_pkg::OFS_RUN_MON: begin
				cur_word[15:0] = running_monitor_view; // R9
				cur_word[16] = running; // R9
			end
			default: cur_word = 32'h0000_0000;
		endcase
	end

	// Byte lanes not selected keep the stored value
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wr_word[8*i +: 8] = WB_SEL_I[i] ? WB_DAT_I[8*i +: 8]
				: cur_word[8*i +: 8];
		end
	end

	assign next_rdata = cur_word;

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			WB_DAT_O <= 32'h0000_0000;
		end else if (bus_req & ~WB_ACK_O & ~WB_WE_I) begin
			WB_DAT_O <= next_rdata;
		end
	end

	// Control register
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			enable_input_map <= sso_pkg::RST_EN_MAP;
			ctrl_mode        <= sso_pkg::RST_MODE;
			serial_cmd       <= 1'b0;
		end else if (wr_now && WB_ADR_I == sso_pkg::OFS_CTRL) begin
			enable_input_map <= wr_word[sso_pkg::CTRL_MAP_LSB +: 4];
			ctrl_mode <= sso_pkg::sso_mode_t'(
				wr_word[sso_pkg::CTRL_MODE_LSB +: 2]);
			serial_cmd <= wr_word[sso_pkg::CTRL_SERIAL];
		end
	end

	// Done width saturates at its top value
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			position_done_width <= sso_pkg::RST_DONE_W; // R4
		end else if (wr_now && WB_ADR_I == sso_pkg::OFS_DONE_W) begin
			if (wr_word[7:0] > sso_pkg::DONE_W_MAX) begin
				position_done_width <= sso_pkg::DONE_W_MAX; // R4
			end else begin
				position_done_width <= wr_word[7:0];
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			match_level <= sso_pkg::RST_MATCH;
		end else if (wr_now && WB_ADR_I == sso_pkg::OFS_MATCH) begin
			match_level <= wr_word[15:0];
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			run_level <= sso_pkg::RST_RUN_LVL;
		end else if (wr_now && WB_ADR_I == sso_pkg::OFS_RUN_LVL) begin
			run_level <= wr_word[15:0];
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			output_select_first <= sso_pkg::RST_OSEL1; // R10
		end else if (wr_now && WB_ADR_I == sso_pkg::OFS_OSEL1) begin
			output_select_first <= wr_word[15:0];
		end
	end

	// Enable pin passes two flops before use
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			son_meta <= 1'b1;
			son_sync <= 1'b1;
		end else begin
			son_meta <= SERVO_ON_N;
			son_sync <= son_meta;
		end
	end

	// Any map other than the forced value follows the pin
	always_comb begin
		if (enable_input_map == sso_pkg::EN_MAP_FORCED) begin
			next_enable = 1'b1; // R2
		end else begin
			next_enable = ~son_sync; // R1 R2
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			SERVO_ENABLE <= 1'b0;
		end else begin
			SERVO_ENABLE <= next_enable; // R1
		end
	end

	// Position error in gear pulses or in position units
	assign done_c.a     = serial_cmd ? POS_ERR_UNIT : POS_ERR_PULSE; // R5
	assign done_c.b     = 16'sh0000;
	assign done_c.limit = {8'h00, position_done_width};
	assign done_c.above = 1'b0;

	assign match_c.a     = SPEED_REF;
	assign match_c.b     = MOTOR_SPEED;
	assign match_c.limit = match_level;
	assign match_c.above = 1'b0;

	assign run_c.a     = MOTOR_SPEED;
	assign run_c.b     = 16'sh0000;
	assign run_c.limit = run_level;
	assign run_c.above = 1'b1;

	sso_cmp u_done (
		.c (done_c.cmp)
	);

	sso_cmp u_match (
		.c (match_c.cmp)
	);

	sso_cmp u_run (
		.c (run_c.cmp)
	);

	// Compare results are captured each clock
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			pos_done    <= 1'b0;
			speed_match <= 1'b0;
			running     <= 1'b0;
		end else begin
			pos_done    <= done_c.hit; // R3 R13
			speed_match <= match_c.hit; // R7 R13
			running     <= run_c.hit; // R8 R13
		end
	end

	assign speed_mag = MOTOR_SPEED[15] ? 16'(-MOTOR_SPEED) : MOTOR_SPEED;

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			running_monitor_view <= 16'h0000;
		end else begin
			running_monitor_view <= speed_mag;
		end
	end

	// Shared slot content depends on control mode
	always_comb begin
		unique case (ctrl_mode)
			sso_pkg::SSO_MODE_POS:    slot_flag = done_c.hit; // R6
			sso_pkg::SSO_MODE_SPEED:  slot_flag = match_c.hit; // R6
			sso_pkg::SSO_MODE_TORQUE: slot_flag = 1'b1; // R6
			default:                  slot_flag = done_c.hit;
		endcase
	end

	sso_map u_map (
		.slot_flag (slot_flag),
		.run_flag  (run_c.hit),
		.slot_sel  (output_select_first[3:0]), // R10
		.run_sel   (output_select_first[7:4]), // R10
		.pair      (pair_act) // R12
	);

	// Active-low pins, all from flops
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			POS_DONE_N    <= 1'b1;
			SPEED_MATCH_N <= 1'b1;
			RUNNING_N     <= 1'b1;
			OUT_PAIR_N    <= 3'h7;
		end else begin
			POS_DONE_N    <= ~done_c.hit; // R3
			SPEED_MATCH_N <= ~match_c.hit; // R7
			RUNNING_N     <= ~run_c.hit; // R8 R9
			OUT_PAIR_N    <= ~pair_act; // R6 R12
		end
	end
endmodule // sso_top

// File: dv/sso_top_asserts.sv
// Purpose: Port-level checks of the servo status block
// Assumes: Bound to sso_top; thresholds are never negative
// Notes:   Zero and equal-speed cases hold for any threshold setting; full-scale cases need thresholds below 32767
`timescale 1ns/1ns
module sso_top_asserts (
	input wire logic        CLK_SYS,
	input wire logic        RST_B,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_ACK_O,
	input wire logic        SERVO_ON_N,
	input wire logic        SERVO_ENABLE,
	input wire logic [15:0] POS_ERR_PULSE,
	input wire logic [15:0] POS_ERR_UNIT,
	input wire logic [15:0] SPEED_REF,
	input wire logic [15:0] MOTOR_SPEED,
	input wire logic        POS_DONE_N,
	input wire logic        SPEED_MATCH_N,
	input wire logic        RUNNING_N
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	ack_answer_a: assert property (
		WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("request not acknowledged");
	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	en_follow_a: assert property (
		(!SERVO_ON_N) [*5] |-> SERVO_ENABLE)
		else $error("servo not enabled by low pin");
	done_zero_a: assert property (
		POS_ERR_PULSE == 16'h0000 && POS_ERR_UNIT == 16'h0000 |=> !POS_DONE_N)
		else $error("done not asserted at zero error");
	match_eq_a: assert property (
		SPEED_REF == MOTOR_SPEED |=> !SPEED_MATCH_N)
		else $error("match not asserted at equal speed");
	match_far_a: assert property (
		SPEED_REF == 16'h7FFF && MOTOR_SPEED == 16'h0000 |=> SPEED_MATCH_N)
		else $error("match asserted at large error");
	run_stop_a: assert property (
		MOTOR_SPEED == 16'h0000 |=> RUNNING_N)
		else $error("running asserted at standstill");
	run_fast_a: assert property (
		MOTOR_SPEED == 16'h7FFF |=> !RUNNING_N)
		else $error("running not asserted at full speed");
	cover property (!RUNNING_N ##1 RUNNING_N);
	cover property (!SPEED_MATCH_N && !POS_DONE_N);
	cover property ($fell(SERVO_ENABLE));
endmodule // sso_top_asserts
bind sso_top sso_top_asserts u_chk (.CLK_SYS, .RST_B, .WB_CYC_I, .WB_STB_I,
	.WB_ACK_O, .SERVO_ON_N, .SERVO_ENABLE, .POS_ERR_PULSE, .POS_ERR_UNIT,
	.SPEED_REF, .MOTOR_SPEED, .POS_DONE_N, .SPEED_MATCH_N, .RUNNING_N);

// File: dv/sso_host.sv
// Purpose: Host controller driving the enable pin and speed reference
// Assumes: Same clock as the servo block
// Notes:   step sets how fast a stop ramps down
`timescale 1ns/1ns
module sso_host (
	input  wire logic        clk,
	input  wire logic        run,
	input  wire logic [15:0] target,
	input  wire logic [7:0]  step,
	output      logic        servo_on_n,
	output      logic [15:0] speed_ref
);
	int r;
	int s;
	initial begin
		servo_on_n = 1'b1;
		speed_ref = 16'h0000;
	end
	// Stops by ramping the reference toward zero; the same edge that zeroes it also drops the enable
	always @(posedge clk) begin
		r = int'($signed(speed_ref));
		s = int'(step);
		if (run) begin
			servo_on_n <= 1'b0;
			speed_ref <= target;
		end else if (r > s)
			speed_ref <= speed_ref - 16'(s);
		else if (-r > s)
			speed_ref <= speed_ref + 16'(s);
		else begin
			speed_ref <= 16'h0000;
			servo_on_n <= 1'b1;
		end
	end
endmodule // sso_host

// File: dv/test_servo_status_outputs.sv
// Purpose: Self-checking bench of the servo status block
// Assumes: Bus master per classic Wishbone single cycle
// Notes:   Pins compared with a behavioural model every cycle
`timescale 1ns/1ns
module test_servo_status_outputs;
	logic        clk, rst_b, cyc, stb, we, ack, son_n, run, chk_on;
	logic        en, done_n, match_n, run_n, e_en, e_done, e_match, e_run;
	logic [7:0]  adr, osel, step;
	logic [3:0]  sel;
	logic [6:0]  ctrl;
	logic [31:0] dat, rdat, r, rnd;
	logic [15:0] pp, pu, sref, mspd, target;
	logic [2:0]  pair_n, e_pair, q, p;
	int          failures, cmp_count, done_w, match, lvl;
	logic        fd, fm, fr, slot;
	sso_top uut (.CLK_SYS(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .SERVO_ON_N(son_n),
		.POS_ERR_PULSE(pp), .POS_ERR_UNIT(pu), .SPEED_REF(sref),
		.MOTOR_SPEED(mspd), .SERVO_ENABLE(en), .POS_DONE_N(done_n),
		.SPEED_MATCH_N(match_n), .RUNNING_N(run_n), .OUT_PAIR_N(pair_n));
	sso_host host (.clk(clk), .run(run), .target(target), .step(step),
		.servo_on_n(son_n), .speed_ref(sref));
	function automatic int ia(logic [15:0] v);
		return $signed(v) < 0 ? -int'($signed(v)) : int'($signed(v));
	endfunction
	function automatic logic [31:0] lfsr(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [15:0] sv(logic [31:0] v);
		return 16'(int'(v[6:0] % 81) - 40);
	endfunction
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			done_w = 7;
			match = 10;
			lvl = 20;
			ctrl = 7'h08;
			osel = 8'h00;
			q <= 3'h7;
		end else begin
			fd = ia(ctrl[6] ? pu : pp) <= done_w;
			fm = int'($signed(sref)) - int'($signed(mspd)) <= match &&
				int'($signed(mspd)) - int'($signed(sref)) <= match;
			fr = ia(mspd) > lvl;
			slot = ctrl[5:4] == 2'h2 ? 1'b1 : ctrl[5:4] == 2'h1 ? fm : fd;
			p = 3'h0;
			case (osel[3:0])
				4'h0, 4'h1: p[0] = slot;
				4'h2: p[1] = slot;
				4'h3: p[2] = slot;
				default: ;
			endcase
			case (osel[7:4])
				4'h0, 4'h2: p[1] = p[1] | fr;
				4'h1: p[0] = p[0] | fr;
				4'h3: p[2] = p[2] | fr;
				default: ;
			endcase
			{e_done, e_match, e_run, e_pair} <= {!fd, !fm, !fr, ~p};
			e_en <= ctrl[3:0] == 4'h7 || !q[1];
			q <= {q[1:0], son_n};
			if (cyc && stb && we && ack)
				case (adr)
					sso_pkg::OFS_CTRL: ctrl = dat[6:0];
					sso_pkg::OFS_DONE_W: done_w = dat[7:0] > 8'hFA ? 250 : dat[7:0];
					sso_pkg::OFS_MATCH: match = dat[15:0];
					sso_pkg::OFS_RUN_LVL: lvl = dat[15:0];
					sso_pkg::OFS_OSEL1: osel = dat[7:0];
					default: ;
				endcase
		end
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [2:0] e, input logic [2:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{cyc, stb, we, sel, adr, dat} <= {2'h3, w, 4'hF, a, d};
		// Ack and read data are taken at the rising edge that sees ack
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			failures++;
			end_of_test();
		end
		r = rdat;
		{cyc, stb, we} <= 3'h0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		cmp_count++;
		if (r !== e) begin
			failures++;
			$display("mismatch read %0h expected %0h seen %0h", a, e, r);
		end
	endtask
	always @(negedge clk) if (chk_on) begin
		chk("enable", {2'h0, e_en}, {2'h0, en});
		chk("done", {2'h0, e_done}, {2'h0, done_n});
		chk("match", {2'h0, e_match}, {2'h0, match_n});
		chk("running", {2'h0, e_run}, {2'h0, run_n});
		chk("pairs", e_pair, pair_n);
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		end_of_test();
	end
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		{rst_b, cyc, stb, we, run, chk_on, sel, adr, dat} = '0;
		{pp, pu, mspd, target, step, failures, cmp_count} = '0;
		rnd = 32'h00014DDE;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		rd_chk(sso_pkg::OFS_DONE_W, 32'h00000007);
		rd_chk(sso_pkg::OFS_OSEL1, 32'h00000000);
		rd_chk(8'h1C, 32'h00000000);
		wb(1'b1, sso_pkg::OFS_DONE_W, 32'h000000FF);
		rd_chk(sso_pkg::OFS_DONE_W, 32'h000000FA);
		chk_on <= 1'b1;
		for (int m = 0; m < 12; m++) begin
			wb(1'b1, sso_pkg::OFS_CTRL, 32'((m / 4 % 2) << 6 | (m % 4) << 4 |
				(m % 3 == 0 ? 7 : m % 3 == 1 ? 0 : 8)));
			wb(1'b1, sso_pkg::OFS_OSEL1, {24'h0, rnd[7:0]});
			wb(1'b1, sso_pkg::OFS_DONE_W, 32'(rnd[13:8] % 41));
			wb(1'b1, sso_pkg::OFS_MATCH, 32'(rnd[19:14] % 41));
			wb(1'b1, sso_pkg::OFS_RUN_LVL, 32'(rnd[25:20] % 41));
			run <= m % 3 != 2;
			step <= m % 2 ? 8'h01 : 8'h28;
			repeat (40) begin
				@(posedge clk);
				rnd = lfsr(rnd);
				{pp, pu, mspd, target} <= {sv(rnd), sv(rnd >> 7),
					sv(rnd >> 14), sv(rnd >> 21)};
			end
			$display("test mode %0d done", m);
		end
		// Zero error, full-scale reference and speed, then a small reverse
		@(posedge clk);
		{pp, pu, mspd, target} <= {48'h0, 16'h7FFF};
		run <= 1'b1;
		repeat (4) @(posedge clk);
		mspd <= 16'h7FFF;
		repeat (3) @(posedge clk);
		mspd <= 16'hFFF6;
		repeat (8) @(posedge clk);
		rd_chk(sso_pkg::OFS_STATUS, {25'h0, ~e_pair, e_en, ~e_run, ~e_match,
			~e_done});
		rd_chk(sso_pkg::OFS_RUN_MON, {15'h0, 10 > lvl, 16'h000A});
		$display("test extremes and monitor done");
		end_of_test();
	end
endmodule // test_servo_status_outputs
